// ===== dv/skin_tone_source.sv
// Upstream skin-tone stage model feeding the gamut front end
`timescale 1ns/1ps
module skin_tone_source
  import color_pipe_pkg::*;
(
  input wire logic mclk,
  input wire logic req_go,
  input wire logic [35:0] req_pix,
  output logic skin_tone_valid,
  output logic [11:0] skin_tone_y,
  output logic [11:0] skin_tone_u,
  output logic [11:0] skin_tone_v
);
  // ==========================================
  // Source
  initial begin
    skin_tone_valid = 1'b0;
    {skin_tone_y, skin_tone_u, skin_tone_v} = 36'h0;
  end
  // Idle lines toggle so a stale pixel is never read as a new one
  always @(posedge mclk) begin
    skin_tone_valid <= req_go;
    if (req_go) begin
      {skin_tone_y, skin_tone_u, skin_tone_v} <= req_pix;
    end else begin
      {skin_tone_y, skin_tone_u, skin_tone_v} <= ~{skin_tone_y, skin_tone_u, skin_tone_v};
    end
  end
endmodule

// ===== dv/video_color_pipe_adjust_csc_tb_top.sv
// Self-checking bench for the colour pipe
`timescale 1ns/1ps
`include "color_pipe_params.svh"
module video_color_pipe_adjust_csc_tb_top
  import color_pipe_pkg::*;
;
  logic mclk, rstn, rd, wr, pv, go, wreq, ov, orgb, stv, cv, cfr;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  comp_t c1, c2, c3;
  logic [51:0] ow;
  logic [35:0] gp;
  logic [11:0] sty, stu, stvv;
  logic signed [13:0] cl;
  logic [12:0] cc;
  logic [9:0] ch;
  logic [7:0] ra [10];
  logic [15:0] re [10];
  int err_count = 0;
  int num_checks = 0;

  video_color_pipe_adjust_csc video_color_pipe_adjust_csc_i (.mclk(mclk), .rstn(rstn),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .pix_in_valid(pv), .pix_in_c1(c1),
    .pix_in_c2(c2), .pix_in_c3(c3), .pix_out_valid(ov), .pix_out_word(ow),
    .pix_out_is_rgb(orgb), .skin_tone_valid(stv), .skin_tone_y(sty), .skin_tone_u(stu),
    .skin_tone_v(stvv), .color_ctl_valid(cv), .color_ctl_light(cl), .color_ctl_chroma(cc),
    .color_ctl_hue(ch), .color_ctl_full_range(cfr));
  skin_tone_source skin_tone_source_i (.mclk(mclk), .req_go(go), .req_pix(gp),
    .skin_tone_valid(stv), .skin_tone_y(sty), .skin_tone_u(stu), .skin_tone_v(stvv));

  // ==========================================
  // Tasks
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge mclk); while (wreq !== 1'b0);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rv, exp);
  endtask
  task automatic pix(input comp_t a, input comp_t b, input comp_t c, input logic [51:0] e);
    @(posedge mclk);
    pv <= 1'b1;
    c1 <= a;
    c2 <= b;
    c3 <= c;
    @(posedge mclk);
    pv <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check(ov, 64'h1);
    check(ow, e);
  endtask
  task automatic gam(input logic [35:0] p, input logic [36:0] e, input logic fr);
    @(posedge mclk);
    go <= 1'b1;
    gp <= p;
    @(posedge mclk);
    go <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check(cv, 64'h1);
    check({cl, cc, ch}, e);
    check(cfr, fr);
  endtask

  // ==========================================
  // Tests
  initial begin
    #(40 * 4000);
    err_count++;
    print_verdict;
  end
  initial begin
    {rstn, rd, wr, pv, go, addr, wdata, c1, c2, c3, gp} = '0;
    ra = '{`REG_CTRL, `REG_CONTRAST, `REG_COS_CS, `REG_SIN_CS, `REG_COEF_BASE, 8'h24,
      8'h30, `REG_COEF_LAST, `REG_OFS_IN_BASE, 8'h1C};
    re = '{16'h0, 16'h100, 16'h100, 16'h0, 16'h100, 16'h0, 16'h100, 16'h100, 16'h0, 16'h0};
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    foreach (ra[i]) rchk(ra[i], {16'h0, re[i]});
    pix(16'h1234, 16'h0900, 16'h0700, {48'h1234_0900_0700, 4'h0});
    pix(16'h0080, 16'h0800, 16'h0800, {48'h0080_0800_0800, 4'h0});
    bus(1'b1, `REG_CTRL, 32'h6);
    bus(1'b1, `REG_ALPHA, 32'hA);
    pix(16'h0400, 16'h0800, 16'h0800, {48'h0400_0800_0800, 4'hA});
    check(orgb, 64'h1);
    bus(1'b1, `REG_CTRL, 32'h0);
    bus(1'b1, `REG_CONTRAST, 32'h200);
    bus(1'b1, `REG_BRIGHT, 32'h10);
    pix(16'h0300, 16'h0900, 16'h0700, {48'h0510_0900_0700, 4'h0});
    pix(16'hFFFF, 16'h0800, 16'h0800, {48'hFFFF_0800_0800, 4'h0});
    pix(16'h0000, 16'h0800, 16'h0800, {48'h0000_0800_0800, 4'h0});
    bus(1'b1, `REG_BRIGHT, 32'h0);
    pix(16'h0080, 16'h0800, 16'h0800, {48'h0000_0800_0800, 4'h0});
    bus(1'b1, `REG_CONTRAST, 32'h100);
    bus(1'b1, `REG_COS_CS, 32'h0);
    bus(1'b1, `REG_SIN_CS, 32'h100);
    pix(16'h0500, 16'h0900, 16'h0880, {48'h0500_0880_0700, 4'h0});
    bus(1'b1, `REG_COS_CS, 32'h200);
    bus(1'b1, `REG_SIN_CS, 32'h0);
    pix(16'h0500, 16'hF000, 16'h0700, {48'h0500_FFFF_0600, 4'h0});
    // Amplifier bypassed so only the matrix path shapes the pixel
    bus(1'b1, `REG_CTRL, 32'h1);
    bus(1'b1, 8'h24, 32'h100);
    bus(1'b1, `REG_OFS_IN_BASE, 32'h10);
    bus(1'b1, `REG_OFS_OUT_LAST, 32'hFF00);
    pix(16'h1000, 16'h0200, 16'h0080, {48'h1210_0200_0000, 4'h0});
    rchk(`REG_COUNT, 32'hA);
    bus(1'b1, `REG_COUNT, 32'h0);
    bus(1'b1, 8'h1C, 32'h55);
    rchk(`REG_COUNT, 32'hA);
    rchk(8'h1C, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h8);
    gam(36'h500_B80_800, {14'd1197, 13'd1023, 10'd0}, 1'b1);
    bus(1'b1, `REG_CTRL, 32'h0);
    gam(36'h500_800_B80, {14'd1197, 13'd1023, 10'd256}, 1'b0);
    gam(36'h000_800_480, {14'h3ED4, 13'd1024, 10'd768}, 1'b0);
    gam(36'h500_480_800, {14'd1197, 13'd1024, 10'd512}, 1'b0);
    gam(36'h100_800_800, {14'd0, 13'd0, 10'd0}, 1'b0);
    print_verdict;
  end
endmodule

// ===== logic/chroma_hue_converter.sv
// xvYCC decode and lightness/chroma/hue conversion for the gamut front end
`timescale 1ns/1ps
`include "color_pipe_params.svh"
module chroma_hue_converter
  import color_pipe_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  hue_if.conv hif
);

  // ==========================================
  // Hue angle: polynomial arctangent on one octant, then folded
  function automatic logic [9:0] hue_index(input logic signed [12:0] du,
                                           input logic signed [12:0] dv);
    logic [11:0] au;
    logic [11:0] av;
    logic [11:0] mx;
    logic [11:0] mn;
    logic [23:0] quo;
    logic [12:0] x;
    logic [25:0] x2;
    logic [31:0] t;
    logic [31:0] scaled;
    logic [9:0] a;
    au = du[12] ? 12'(-du) : 12'(du);
    av = dv[12] ? 12'(-dv) : 12'(dv);
    mx = (av > au) ? av : au;
    mn = (av > au) ? au : av;
    quo = (mx == 12'h000) ? 24'h000000 : ({mn, 12'h000} / {12'h000, mx});
    x = quo[12:0];
    x2 = 26'(x) * 26'(x);
    t = (`ATAN_K1 * 32'(x) - `ATAN_K2 * 32'(x2[25:12])) >> 12;
    t = (t > `ATAN_K0) ? t - `ATAN_K0 : 32'h00000000;
    scaled = t * `RAD_TO_IDX;
    a = {2'b00, scaled[19:12]};
    if (av > au) begin
      a = `HUE_QUARTER - a;
    end
    if (du[12] && !dv[12]) begin
      a = `HUE_HALF - a;
    end else if (du[12] && dv[12]) begin
      a = `HUE_HALF + a;
    end else if (dv[12]) begin
      a = 10'h000 - a;
    end
    return a;
  endfunction

  logic dec_valid;
  logic signed [13:0] dec_y;
  logic signed [12:0] dec_u;
  logic signed [12:0] dec_v;
  logic signed [26:0] next_py;
  logic signed [26:0] next_pu;
  logic signed [26:0] next_pv;
  logic [11:0] abs_u;
  logic [11:0] abs_v;

  // ==========================================
  // Decode stage
  always_comb begin
    next_py = ($signed({1'b0, hif.in_y}) - `XV_Y_BLACK) * `XV_Y_GAIN;
    next_pu = ($signed({1'b0, hif.in_u}) - `XV_C_MID) * `XV_C_GAIN;
    next_pv = ($signed({1'b0, hif.in_v}) - `XV_C_MID) * `XV_C_GAIN;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dec_valid <= 1'b0;
      dec_y <= 14'sh0000;
      dec_u <= 13'sh0000;
      dec_v <= 13'sh0000;
    end else begin
      dec_valid <= hif.in_valid;
      dec_y <= next_py[25:12];
      dec_u <= next_pu[24:12];
      dec_v <= next_pv[24:12];
    end
  end

  // ==========================================
  // Conversion stage
  assign abs_u = dec_u[12] ? 12'(-dec_u) : 12'(dec_u);
  assign abs_v = dec_v[12] ? 12'(-dec_v) : 12'(dec_v);

  // Magnitude uses max + 3/8 min, trading a few percent of error for no root
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hif.out_valid <= 1'b0;
      hif.light <= 14'sh0000;
      hif.chroma <= 13'h0000;
      hif.hue <= 10'h000;
    end else begin
      hif.out_valid <= dec_valid;
      hif.light <= dec_y;
      hif.chroma <= (abs_u > abs_v) ?
        13'(abs_u) + 13'(abs_v >> 2) + 13'(abs_v >> 3) :
        13'(abs_v) + 13'(abs_u >> 2) + 13'(abs_u >> 3);
      hif.hue <= hue_index(dec_u, dec_v);
    end
  end

  // ==========================================
  // Checks
  AST_DECODE_BLACK: assert property (@(posedge mclk) disable iff (!rstn)
    hif.in_valid && hif.in_y == 12'h100 |=> dec_valid && dec_y == 14'sh0000)
    else $error("black luma did not decode to zero");
  AST_NEUTRAL_CHROMA: assert property (@(posedge mclk) disable iff (!rstn)
    hif.in_valid && hif.in_u == 12'h800 && hif.in_v == 12'h800
      |-> ##2 hif.out_valid && hif.chroma == 13'h0000)
    else $error("neutral pixel has non-zero chroma");
  AST_HUE_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
    hif.in_valid && hif.in_v == 12'h800 && hif.in_u > 12'h900
      |-> ##2 hif.out_valid && hif.hue == 10'h000)
    else $error("positive u axis not at hue zero");
  AST_HUE_HALF: assert property (@(posedge mclk) disable iff (!rstn)
    hif.in_valid && hif.in_v == 12'h800 && hif.in_u < 12'h700
      |-> ##2 hif.hue == `HUE_HALF)
    else $error("negative u axis not at half turn");

endmodule

// ===== logic/color_pipe_params.svh
// Register offsets, field positions, reset values and arithmetic constants of the colour pipe
`ifndef COLOR_PIPE_PARAMS_SVH
`define COLOR_PIPE_PARAMS_SVH

// ==========================================
// Register map (byte addresses)
`define REG_CTRL 8'h00
`define REG_ALPHA 8'h04
`define REG_CONTRAST 8'h08
`define REG_BRIGHT 8'h0C
`define REG_COS_CS 8'h10
`define REG_SIN_CS 8'h14
`define REG_COUNT 8'h18
`define REG_COEF_BASE 8'h20
`define REG_COEF_LAST 8'h40
`define REG_OFS_IN_BASE 8'h50
`define REG_OFS_IN_LAST 8'h58
`define REG_OFS_OUT_BASE 8'h60
`define REG_OFS_OUT_LAST 8'h68

// ==========================================
// Control field positions
`define CTRL_IN_RGB 0
`define CTRL_OUT_RGB 1
`define CTRL_ALPHA_SEL 2
`define CTRL_GAMUT_MODE 3

// ==========================================
// Reset values
`define RST_CTRL 4'h0
`define RST_ALPHA 4'h0
`define RST_UNITY 16'h0100
`define RST_ZERO 16'h0000

// ==========================================
// Amplifier and matrix arithmetic
`define GAIN_FRAC 8
`define GAIN_HALF 36'sh000000080
`define BLACK_LEVEL 17'sh00100
`define CHROMA_MID 17'sh00800
`define COMP_MAX 36'sh00000FFFF

// ==========================================
// Gamut front end arithmetic
`define XV_Y_GAIN 14'sh12B4
`define XV_C_GAIN 14'sh1249
`define XV_Y_BLACK 13'sh0100
`define XV_C_MID 13'sh0800
`define ATAN_K1 32'h00001146
`define ATAN_K2 32'h0000049C
`define ATAN_K0 32'h00000014
`define RAD_TO_IDX 32'h000000A3
`define HUE_QUARTER 10'h100
`define HUE_HALF 10'h200

`endif

// ===== logic/color_pipe_pkg.sv
// Types shared by the colour pipe modules
package color_pipe_pkg;
  typedef logic [15:0] comp_t;
  typedef logic signed [15:0] coef_t;
  typedef enum logic {
    GAMUT_CLIP,
    GAMUT_FULL_RANGE
  } gamut_mode_t;
endpackage

// ===== logic/hue_if.sv
// Signals between the pipe and its chroma/hue converter
`timescale 1ns/1ps
interface hue_if;
  logic in_valid;
  logic [11:0] in_y;
  logic [11:0] in_u;
  logic [11:0] in_v;
  logic out_valid;
  logic signed [13:0] light;
  logic [12:0] chroma;
  logic [9:0] hue;
  modport conv (
    input in_valid, in_y, in_u, in_v,
    output out_valid, light, chroma, hue
  );
  modport pipe (
    output in_valid, in_y, in_u, in_v,
    input out_valid, light, chroma, hue
  );
endinterface

// ===== logic/video_color_pipe_adjust_csc.sv
// Colour pipe: luma/chroma amplifier, matrix converter, repacker and gamut front end
`timescale 1ns/1ps
`include "color_pipe_params.svh"
module video_color_pipe_adjust_csc
  import color_pipe_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pix_in_valid,
  input wire logic [15:0] pix_in_c1,
  input wire logic [15:0] pix_in_c2,
  input wire logic [15:0] pix_in_c3,
  output logic pix_out_valid,
  output logic [51:0] pix_out_word,
  output logic pix_out_is_rgb,
  input wire logic skin_tone_valid,
  input wire logic [11:0] skin_tone_y,
  input wire logic [11:0] skin_tone_u,
  input wire logic [11:0] skin_tone_v,
  output logic color_ctl_valid,
  output logic signed [13:0] color_ctl_light,
  output logic [12:0] color_ctl_chroma,
  output logic [9:0] color_ctl_hue,
  output logic color_ctl_full_range
);

  // ==========================================
  // Arithmetic helpers
  function automatic logic signed [35:0] descale(input logic signed [35:0] x);
    return (x + `GAIN_HALF) >>> `GAIN_FRAC;
  endfunction

  function automatic comp_t clip16(input logic signed [35:0] x);
    if (x < 36'sh000000000) begin
      return 16'h0000;
    end else if (x > `COMP_MAX) begin
      return 16'hFFFF;
    end
    return x[15:0];
  endfunction

  // ==========================================
  // Registers
  logic [3:0] ctrl;
  logic [3:0] pipe_alpha;
  comp_t contrast;
  coef_t brightness;
  coef_t cos_cs;
  coef_t sin_cs;
  coef_t coef [0:8];
  coef_t ofs_in [0:2];
  coef_t ofs_out [0:2];
  logic [31:0] pix_count;
  logic bus_req;
  logic wr_en;
  logic [3:0] idx;

  assign bus_req = avs_read || avs_write;
  assign wr_en = avs_write && !avs_waitrequest;

  // One wait state on every access; read data loads on the first edge, the write lands on the second
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    idx = 4'h0;
    if (avs_address >= `REG_COEF_BASE && avs_address <= `REG_COEF_LAST) begin
      idx = 4'((avs_address - `REG_COEF_BASE) >> 2);
    end else if (avs_address >= `REG_OFS_IN_BASE && avs_address <= `REG_OFS_IN_LAST) begin
      idx = 4'((avs_address - `REG_OFS_IN_BASE) >> 2);
    end else if (avs_address >= `REG_OFS_OUT_BASE && avs_address <= `REG_OFS_OUT_LAST) begin
      idx = 4'((avs_address - `REG_OFS_OUT_BASE) >> 2);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      if (avs_address[1:0] != 2'b00) begin
        avs_readdata <= 32'h00000000;
      end else if (avs_address == `REG_CTRL) begin
        avs_readdata <= {28'h0000000, ctrl};
      end else if (avs_address == `REG_ALPHA) begin
        avs_readdata <= {28'h0000000, pipe_alpha};
      end else if (avs_address == `REG_CONTRAST) begin
        avs_readdata <= {16'h0000, contrast};
      end else if (avs_address == `REG_BRIGHT) begin
        avs_readdata <= {16'h0000, brightness};
      end else if (avs_address == `REG_COS_CS) begin
        avs_readdata <= {16'h0000, cos_cs};
      end else if (avs_address == `REG_SIN_CS) begin
        avs_readdata <= {16'h0000, sin_cs};
      end else if (avs_address == `REG_COUNT) begin
        avs_readdata <= pix_count;
      end else if (avs_address >= `REG_COEF_BASE && avs_address <= `REG_COEF_LAST) begin
        avs_readdata <= {16'h0000, coef[idx]};
      end else if (avs_address >= `REG_OFS_IN_BASE && avs_address <= `REG_OFS_IN_LAST) begin
        avs_readdata <= {16'h0000, ofs_in[idx[1:0]]};
      end else if (avs_address >= `REG_OFS_OUT_BASE && avs_address <= `REG_OFS_OUT_LAST) begin
        avs_readdata <= {16'h0000, ofs_out[idx[1:0]]};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl <= `RST_CTRL;
      pipe_alpha <= `RST_ALPHA;
      contrast <= `RST_UNITY;
      brightness <= `RST_ZERO;
      cos_cs <= `RST_UNITY;
      sin_cs <= `RST_ZERO;
      for (int i = 0; i < 9; i++) begin
        coef[i] <= (i % 4 == 0) ? `RST_UNITY : `RST_ZERO;
      end
      for (int i = 0; i < 3; i++) begin
        ofs_in[i] <= `RST_ZERO;
        ofs_out[i] <= `RST_ZERO;
      end
    end else if (wr_en && avs_address[1:0] == 2'b00) begin
      if (avs_address == `REG_CTRL) begin
        ctrl <= avs_writedata[3:0];
      end else if (avs_address == `REG_ALPHA) begin
        pipe_alpha <= avs_writedata[3:0];
      end else if (avs_address == `REG_CONTRAST) begin
        contrast <= avs_writedata[15:0];
      end else if (avs_address == `REG_BRIGHT) begin
        brightness <= avs_writedata[15:0];
      end else if (avs_address == `REG_COS_CS) begin
        cos_cs <= avs_writedata[15:0];
      end else if (avs_address == `REG_SIN_CS) begin
        sin_cs <= avs_writedata[15:0];
      end else if (avs_address >= `REG_COEF_BASE && avs_address <= `REG_COEF_LAST) begin
        coef[idx] <= avs_writedata[15:0];
      end else if (avs_address >= `REG_OFS_IN_BASE && avs_address <= `REG_OFS_IN_LAST) begin
        ofs_in[idx[1:0]] <= avs_writedata[15:0];
      end else if (avs_address >= `REG_OFS_OUT_BASE && avs_address <= `REG_OFS_OUT_LAST) begin
        ofs_out[idx[1:0]] <= avs_writedata[15:0];
      end
    end
  end

  // ==========================================
  // Input capture
  logic v1;
  comp_t in1 [0:2];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      v1 <= 1'b0;
      in1 <= '{default: 16'h0000};
    end else begin
      v1 <= pix_in_valid;
      in1 <= '{pix_in_c1, pix_in_c2, pix_in_c3};
    end
  end

  // ==========================================
  // Luma/chroma amplifier
  logic v2;
  comp_t pa [0:2];
  comp_t next_pa [0:2];
  // Centred values held at full product width so no product is cut short
  logic signed [35:0] y_ctr;
  logic signed [35:0] u_ctr;
  logic signed [35:0] v_ctr;
  logic signed [35:0] y_acc;
  logic signed [35:0] u_acc;
  logic signed [35:0] v_acc;

  always_comb begin
    y_ctr = 36'($signed({1'b0, in1[0]}) - `BLACK_LEVEL);
    u_ctr = 36'($signed({1'b0, in1[1]}) - `CHROMA_MID);
    v_ctr = 36'($signed({1'b0, in1[2]}) - `CHROMA_MID);
    y_acc = descale(y_ctr * $signed({1'b0, contrast})) + 36'(brightness) + 36'(`BLACK_LEVEL);
    u_acc = descale(u_ctr * cos_cs + v_ctr * sin_cs) + 36'(`CHROMA_MID);
    v_acc = descale(v_ctr * cos_cs - u_ctr * sin_cs) + 36'(`CHROMA_MID);
    if (ctrl[`CTRL_IN_RGB]) begin
      // Amplifier works on YCbCr only, RGB passes untouched
      next_pa = in1;
    end else begin
      next_pa = '{clip16(y_acc), clip16(u_acc), clip16(v_acc)};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      v2 <= 1'b0;
      pa <= '{default: 16'h0000};
    end else begin
      v2 <= v1;
      pa <= next_pa;
    end
  end

  // ==========================================
  // Matrix converter
  logic v3;
  comp_t cs [0:2];
  comp_t next_cs [0:2];
  logic signed [35:0] vin [0:2];
  logic signed [35:0] acc;

  always_comb begin
    acc = 36'sh000000000;
    for (int j = 0; j < 3; j++) begin
      vin[j] = $signed({20'h00000, pa[j]}) + 36'(ofs_in[j]);
    end
    for (int i = 0; i < 3; i++) begin
      acc = 36'sh000000000;
      for (int j = 0; j < 3; j++) begin
        acc = acc + vin[j] * 36'(coef[i * 3 + j]);
      end
      next_cs[i] = clip16(descale(acc) + 36'(ofs_out[i]));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      v3 <= 1'b0;
      cs <= '{default: 16'h0000};
    end else begin
      v3 <= v2;
      cs <= next_cs;
    end
  end

  // ==========================================
  // Repacker
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pix_out_valid <= 1'b0;
      pix_out_word <= 52'h0000000000000;
      pix_out_is_rgb <= 1'b0;
    end else begin
      pix_out_valid <= v3;
      pix_out_is_rgb <= ctrl[`CTRL_OUT_RGB];
      pix_out_word <= {cs[0], cs[1], cs[2],
        ctrl[`CTRL_ALPHA_SEL] ? pipe_alpha : 4'h0};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pix_count <= 32'h00000000;
    end else if (v3) begin
      pix_count <= pix_count + 32'h00000001;
    end
  end

  // ==========================================
  // Gamut front end, skin tone side in, colour control side out
  hue_if hif ();

  assign hif.in_valid = skin_tone_valid;
  assign hif.in_y = skin_tone_y;
  assign hif.in_u = skin_tone_u;
  assign hif.in_v = skin_tone_v;

  chroma_hue_converter u_conv (
    .mclk(mclk),
    .rstn(rstn),
    .hif(hif)
  );

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      color_ctl_valid <= 1'b0;
      color_ctl_light <= 14'sh0000;
      color_ctl_chroma <= 13'h0000;
      color_ctl_hue <= 10'h000;
      color_ctl_full_range <= GAMUT_CLIP;
    end else begin
      color_ctl_valid <= hif.out_valid;
      color_ctl_light <= hif.light;
      color_ctl_chroma <= hif.chroma;
      color_ctl_hue <= hif.hue;
      color_ctl_full_range <= ctrl[`CTRL_GAMUT_MODE];
    end
  end

  // ==========================================
  // Checks
  logic identity;
  assign identity = coef[0] == 16'sh0100 && coef[4] == 16'sh0100 && coef[8] == 16'sh0100 &&
    coef[1] == 16'sh0000 && coef[2] == 16'sh0000 && coef[3] == 16'sh0000 &&
    coef[5] == 16'sh0000 && coef[6] == 16'sh0000 && coef[7] == 16'sh0000 &&
    ofs_in[0] == 16'sh0000 && ofs_in[1] == 16'sh0000 && ofs_in[2] == 16'sh0000 &&
    ofs_out[0] == 16'sh0000 && ofs_out[1] == 16'sh0000 && ofs_out[2] == 16'sh0000;

  AST_LUMA_UNITY: assert property (@(posedge mclk) disable iff (!rstn)
    v1 && !ctrl[`CTRL_IN_RGB] && contrast == 16'h0100 && brightness == 16'sh0000
      |=> pa[0] == $past(in1[0]))
    else $error("unity contrast changed luma");
  AST_LUMA_BELOW_BLACK: assert property (@(posedge mclk) disable iff (!rstn)
    v1 && !ctrl[`CTRL_IN_RGB] && in1[0] != 16'h0000 && in1[0] < 16'h0100
      && contrast >= 16'h0200
      && brightness == 16'sh0000 |=> pa[0] < $past(in1[0]))
    else $error("luma below black not pushed further down");
  AST_CHROMA_UNITY: assert property (@(posedge mclk) disable iff (!rstn)
    v1 && !ctrl[`CTRL_IN_RGB] && cos_cs == 16'sh0100 && sin_cs == 16'sh0000
      |=> pa[1] == $past(in1[1]) && pa[2] == $past(in1[2]))
    else $error("unity chroma gain changed chroma");
  AST_HUE_SWAP: assert property (@(posedge mclk) disable iff (!rstn)
    v1 && !ctrl[`CTRL_IN_RGB] && cos_cs == 16'sh0000 && sin_cs == 16'sh0100
      |=> pa[1] == $past(in1[2]))
    else $error("quarter turn did not move v into u");
  AST_LUMA_SATURATES: assert property (@(posedge mclk) disable iff (!rstn)
    v1 && !ctrl[`CTRL_IN_RGB] && in1[0] == 16'hFFFF && contrast >= 16'h0100
      && !brightness[15] |=> pa[0] == 16'hFFFF)
    else $error("full scale luma wrapped");
  AST_MATRIX_IDENTITY: assert property (@(posedge mclk) disable iff (!rstn)
    v2 && identity |=> cs[0] == $past(pa[0]) && cs[2] == $past(pa[2]))
    else $error("identity matrix altered pixel");
  AST_ALPHA_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
    v3 && !ctrl[`CTRL_ALPHA_SEL] |=> pix_out_word[3:0] == 4'h0)
    else $error("alpha bits not zero");
  AST_ALPHA_STATE: assert property (@(posedge mclk) disable iff (!rstn)
    v3 && ctrl[`CTRL_ALPHA_SEL] |=> pix_out_word[3:0] == $past(pipe_alpha))
    else $error("pipe alpha not packed");
  AST_LATENCY: assert property (@(posedge mclk) disable iff (!rstn)
    pix_in_valid |-> ##4 pix_out_valid)
    else $error("pixel lost in pipe");
  AST_BUS_WAIT: assert property (@(posedge mclk) disable iff (!rstn)
    bus_req && !avs_waitrequest |-> $past(avs_waitrequest) && $past(bus_req))
    else $error("access completed without a wait state");

  COV_ALPHA: cover property (@(posedge mclk) disable iff (!rstn)
    pix_out_valid && pix_out_word[3:0] != 4'h0);
  COV_CLIP: cover property (@(posedge mclk) disable iff (!rstn)
    v3 && cs[0] == 16'hFFFF);
  COV_WRITE: cover property (@(posedge mclk) disable iff (!rstn) wr_en);
  COV_HUE: cover property (@(posedge mclk) disable iff (!rstn)
    color_ctl_valid && color_ctl_hue > `HUE_HALF);

endmodule
